// file: logic/tpc16_cfg.svh
// offsets, field positions, reset values and codes of the cascaded pwm timer
// Operation
// - in pwm mode channel b keeps separate high-phase and low-phase compare registers
// - channel b count register advances on the tick picked by its clock select
// - high-phase match toggles output, switches to low-phase compare, no flag
// - low-phase match sets channel b flag, toggles output, returns to high-phase
// - high and low phases alternate until counting stops
// - output enable low holds pin low; high lets pin follow the toggle flop
// - writing 1101b to the low nibble selects pwm, runs and starts at once
// - channel b select: 010 fx/2, 011 fx, 100..111 fx/1024,/256,/64,/16
// - cascade channel a select: 010 lower overflow, 011..111 fx/32,/4096,/1024,/256,/64
// - start command clears counter and flag; counting follows if run bit set
// - start bit is writable on its own and clears itself once started
// - run bit low holds the counter value; run bit high counts
// - both mode registers reset to zero
// - channel b control register is bit-writable and resets to zero
// - interval is compare value plus one times the tick period
// - mode select 10 in both channels forms one 16-bit timer
// - in 16-bit mode channel a uses its own output enable flag
// - in 16-bit mode with channel a select 010 each lower counter overflow advances the upper counter
// - in 16-bit mode flag and toggle only when upper and lower matches coincide
`ifndef TPC16_CFG_SVH
`define TPC16_CFG_SVH

// register byte addresses
`define TPC_OFS_B_MODE      12'hf90
`define TPC_OFS_LOW_CMP     12'hf94
`define TPC_OFS_HIGH_CMP    12'hf98
`define TPC_OFS_LOWER_CNT   12'hf9c
`define TPC_OFS_B_CTL       12'hfa0
`define TPC_OFS_STATUS      12'hfa4
`define TPC_OFS_A_MODE      12'hfa8
`define TPC_OFS_UPPER_CMP   12'hfac
`define TPC_OFS_UPPER_CNT   12'hfb0
`define TPC_OFS_A_CTL       12'hfb4

// mode, control and status register fields
`define TPC_MODE_SEL_LO     0
`define TPC_MODE_SEL_HI     1
`define TPC_RUN_BIT         2
`define TPC_START_BIT       3
`define TPC_CSEL_LSB        4
`define TPC_CSEL_MSB        6
`define TPC_OUT_EN_BIT      0
`define TPC_IRQ_BIT         0

// reset values
`define TPC_RST_MODE        8'h00
`define TPC_RST_CTL         8'h00
`define TPC_RST_CMP         8'h00

// mode select codes
`define TPC_MSEL_PWM        2'h1
`define TPC_MSEL_CASCADE    2'h2

// clock select codes
`define TPC_CSEL_2          3'h2
`define TPC_CSEL_3          3'h3
`define TPC_CSEL_4          3'h4
`define TPC_CSEL_5          3'h5
`define TPC_CSEL_6          3'h6
`define TPC_CSEL_7          3'h7

// prescaler exponents (tick = fx / 2**n)
`define TPC_PRE_W           12
`define TPC_DIV_1           1
`define TPC_DIV_4           4
`define TPC_DIV_5           5
`define TPC_DIV_6           6
`define TPC_DIV_8           8
`define TPC_DIV_10          10
`define TPC_DIV_12          12

`endif

// file: logic/tpc16_pkg.sv
// types of the cascaded pwm timer
package tpc16_pkg;
	typedef logic [7:0] tpc16_byte_t;
	typedef logic [2:0] tpc16_csel_t;
	typedef enum logic [1:0] {
		TPC16_MODE_IDLE,
		TPC16_MODE_PWM,
		TPC16_MODE_CASCADE
	} tpc16_mode_t;
	typedef enum logic {
		TPC16_PH_HIGH,
		TPC16_PH_LOW
	} tpc16_phase_t;
endpackage : tpc16_pkg

// file: logic/tpc16_prescale.sv
// free-running prescaler giving one-cycle tick enables at fx / 2**n
`timescale 1ns/1ps
`include "tpc16_cfg.svh"
module tpc16_prescale (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_rst,
	output logic      [`TPC_PRE_W:1]      o_tick
);
	logic [`TPC_PRE_W-1:0] pre_ff;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= pre_ff + 1'b1;
		end
	end

	// tick n fires when the low n bits are all ones
	always_comb begin
		for (int n = 1; n <= `TPC_PRE_W; n++) begin
			o_tick[n] = ((pre_ff & `TPC_PRE_W'((1 << n) - 1)) ==
				`TPC_PRE_W'((1 << n) - 1));
		end
	end
endmodule : tpc16_prescale

// file: logic/tpc16_top.sv
// cascaded 8-bit timer pair with pwm generator and apb register slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "tpc16_cfg.svh"
module tpc16_top (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_psel,
	input  wire logic                     i_penable,
	input  wire logic                     i_pwrite,
	input  wire logic [11:0]              i_paddr,
	input  wire logic [31:0]              i_pwdata,
	input  wire logic [3:0]               i_pstrb,
	output logic      [31:0]              o_prdata,
	output logic                          o_pready,
	output logic                          o_pslverr,
	output logic                          o_wave_out_pin,
	output logic                          o_upper_out_pin,
	output logic                          o_timer_b_irq_flag,
	output logic                          o_timer_b_irq_set_pulse
);
	import tpc16_pkg::*;

	// register state
	tpc16_pkg::tpc16_byte_t timer_b_mode_ctl_ff;
	tpc16_pkg::tpc16_byte_t timer_a_mode_ctl_ff;
	tpc16_pkg::tpc16_byte_t low_phase_compare_ff;
	tpc16_pkg::tpc16_byte_t high_phase_compare_ff;
	tpc16_pkg::tpc16_byte_t upper_compare_value_ff;
	tpc16_pkg::tpc16_byte_t timer_b_control_ff;
	tpc16_pkg::tpc16_byte_t timer_a_control_ff;
	tpc16_pkg::tpc16_byte_t lower_count_reg_ff;
	tpc16_pkg::tpc16_byte_t upper_count_reg_ff;
	tpc16_pkg::tpc16_phase_t phase_ff;
	logic                   timer_b_irq_flag_ff;
	logic                   wave_toggle_ff;
	logic                   irq_pulse_ff;
	logic [31:0]            prdata_ff;
	logic                   pslverr_ff;

	// combinational
	logic [`TPC_PRE_W:1]    tick;
	logic                   wr_acc;
	logic                   setup_rd;
	logic                   addr_hit;
	tpc16_pkg::tpc16_mode_t mode;
	logic                   b_run;
	logic                   b_start;
	logic                   a_start;
	logic                   b_tick;
	logic                   a_tick;
	logic                   lower_ovf;
	logic                   upper_adv;
	logic                   lower_match;
	logic                   upper_match;
	logic                   pwm_match;
	logic                   casc_match;
	logic                   irq_set;
	logic                   irq_clr_sw;
	logic                   wr_b_mode;
	logic                   wr_a_mode;
	logic                   wr_low_cmp;
	logic                   wr_high_cmp;
	logic                   wr_upper_cmp;
	logic                   wr_b_ctl;
	logic                   wr_a_ctl;
	tpc16_pkg::tpc16_byte_t cur_cmp;
	tpc16_pkg::tpc16_byte_t nxt_lower;
	tpc16_pkg::tpc16_byte_t nxt_upper;

	tpc16_prescale i_tpc16_prescale (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.o_tick    (tick)
	);

	// channel b tick select
	function automatic logic sel_tick_b(input tpc16_pkg::tpc16_csel_t csel,
		input logic [`TPC_PRE_W:1] t);
		case (csel)
			`TPC_CSEL_2: sel_tick_b = t[`TPC_DIV_1];
			`TPC_CSEL_3: sel_tick_b = 1'b1;
			`TPC_CSEL_4: sel_tick_b = t[`TPC_DIV_10];
			`TPC_CSEL_5: sel_tick_b = t[`TPC_DIV_8];
			`TPC_CSEL_6: sel_tick_b = t[`TPC_DIV_6];
			`TPC_CSEL_7: sel_tick_b = t[`TPC_DIV_4];
			default:     sel_tick_b = 1'b0;
		endcase
	endfunction : sel_tick_b

	// channel a tick select in cascade, code 010 is the lower overflow
	function automatic logic sel_tick_a(input tpc16_pkg::tpc16_csel_t csel,
		input logic [`TPC_PRE_W:1] t, input logic ovf);
		case (csel)
			`TPC_CSEL_2: sel_tick_a = ovf;
			`TPC_CSEL_3: sel_tick_a = t[`TPC_DIV_5];
			`TPC_CSEL_4: sel_tick_a = t[`TPC_DIV_12];
			`TPC_CSEL_5: sel_tick_a = t[`TPC_DIV_10];
			`TPC_CSEL_6: sel_tick_a = t[`TPC_DIV_8];
			`TPC_CSEL_7: sel_tick_a = t[`TPC_DIV_6];
			default:     sel_tick_a = 1'b0;
		endcase
	endfunction : sel_tick_a

	function automatic tpc16_pkg::tpc16_csel_t csel_of(input tpc16_pkg::tpc16_byte_t m);
		csel_of = m[`TPC_CSEL_MSB:`TPC_CSEL_LSB];
	endfunction : csel_of

	function automatic logic [1:0] msel_of(input tpc16_pkg::tpc16_byte_t m);
		msel_of = {m[`TPC_MODE_SEL_HI], m[`TPC_MODE_SEL_LO]};
	endfunction : msel_of

	function automatic logic is_valid_addr(input logic [11:0] a);
		case (a)
			`TPC_OFS_B_MODE, `TPC_OFS_LOW_CMP, `TPC_OFS_HIGH_CMP,
			`TPC_OFS_LOWER_CNT, `TPC_OFS_B_CTL, `TPC_OFS_STATUS,
			`TPC_OFS_A_MODE, `TPC_OFS_UPPER_CMP, `TPC_OFS_UPPER_CNT,
			`TPC_OFS_A_CTL: is_valid_addr = 1'b1;
			default:        is_valid_addr = 1'b0;
		endcase
	endfunction : is_valid_addr

	// apb decode
	assign wr_acc   = i_psel && i_penable && i_pwrite && i_pstrb[0] && is_valid_addr(i_paddr);
	assign setup_rd = i_psel && !i_penable;
	assign addr_hit = is_valid_addr(i_paddr);
	assign o_pready = 1'b1;
	assign o_prdata = prdata_ff;
	assign o_pslverr = pslverr_ff && i_psel && i_penable;

	// per-register write strobes
	assign wr_b_mode    = wr_acc && i_paddr == `TPC_OFS_B_MODE;
	assign wr_a_mode    = wr_acc && i_paddr == `TPC_OFS_A_MODE;
	assign wr_low_cmp   = wr_acc && i_paddr == `TPC_OFS_LOW_CMP;
	assign wr_high_cmp  = wr_acc && i_paddr == `TPC_OFS_HIGH_CMP;
	assign wr_upper_cmp = wr_acc && i_paddr == `TPC_OFS_UPPER_CMP;
	assign wr_b_ctl     = wr_acc && i_paddr == `TPC_OFS_B_CTL;
	assign wr_a_ctl     = wr_acc && i_paddr == `TPC_OFS_A_CTL;

	// mode decode
	always_comb begin
		if (msel_of(timer_b_mode_ctl_ff) == `TPC_MSEL_PWM) begin
			mode = TPC16_MODE_PWM;
		end else if (msel_of(timer_b_mode_ctl_ff) == `TPC_MSEL_CASCADE &&
			msel_of(timer_a_mode_ctl_ff) == `TPC_MSEL_CASCADE) begin
			mode = TPC16_MODE_CASCADE;
		end else begin
			mode = TPC16_MODE_IDLE;
		end
	end

	assign b_run   = timer_b_mode_ctl_ff[`TPC_RUN_BIT];
	assign b_start = timer_b_mode_ctl_ff[`TPC_START_BIT];
	assign a_start = timer_a_mode_ctl_ff[`TPC_START_BIT];
	// count only while running and not in the start cycle
	assign b_tick  = b_run && !b_start && mode != TPC16_MODE_IDLE &&
		sel_tick_b(csel_of(timer_b_mode_ctl_ff), tick);

	// compare target follows the phase
	assign cur_cmp     = (phase_ff == TPC16_PH_HIGH) ? high_phase_compare_ff
		: low_phase_compare_ff;
	assign lower_match = (lower_count_reg_ff == low_phase_compare_ff);
	assign upper_match = (upper_count_reg_ff == upper_compare_value_ff);
	assign pwm_match   = mode == TPC16_MODE_PWM && b_tick && lower_count_reg_ff == cur_cmp;
	assign casc_match  = mode == TPC16_MODE_CASCADE && b_tick && lower_match &&
		upper_match;
	assign lower_ovf   = mode == TPC16_MODE_CASCADE && b_tick && !casc_match &&
		lower_count_reg_ff == 8'hff;
	assign a_tick      = sel_tick_a(csel_of(timer_a_mode_ctl_ff), tick, lower_ovf);
	assign upper_adv   = mode == TPC16_MODE_CASCADE && !b_start && !a_start && b_run &&
		a_tick;

	// flag set only on low-phase match or coincident cascade match
	assign irq_set = (pwm_match && phase_ff == TPC16_PH_LOW) || casc_match;
	assign irq_clr_sw = wr_acc && i_paddr == `TPC_OFS_STATUS && i_pwdata[`TPC_IRQ_BIT];

	// lower counter next value
	always_comb begin
		if (pwm_match || casc_match) begin
			nxt_lower = 8'h00;
		end else if (b_tick) begin
			nxt_lower = lower_count_reg_ff + 8'h01;
		end else begin
			nxt_lower = lower_count_reg_ff;
		end
	end

	// upper counter next value
	always_comb begin
		if (casc_match) begin
			nxt_upper = 8'h00;
		end else if (upper_adv) begin
			nxt_upper = upper_count_reg_ff + 8'h01;
		end else begin
			nxt_upper = upper_count_reg_ff;
		end
	end

	// channel b mode register; start bit self-clears one cycle after it is seen
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			timer_b_mode_ctl_ff <= `TPC_RST_MODE;
		end else if (wr_b_mode) begin
			timer_b_mode_ctl_ff <= {1'b0, i_pwdata[6:0]};
		end else if (b_start) begin
			timer_b_mode_ctl_ff[`TPC_START_BIT] <= 1'b0;
		end
	end

	// channel a mode register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			timer_a_mode_ctl_ff <= `TPC_RST_MODE;
		end else if (wr_a_mode) begin
			timer_a_mode_ctl_ff <= {1'b0, i_pwdata[6:0]};
		end else if (a_start) begin
			timer_a_mode_ctl_ff[`TPC_START_BIT] <= 1'b0;
		end
	end

	// compare registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			low_phase_compare_ff   <= `TPC_RST_CMP;
			high_phase_compare_ff  <= `TPC_RST_CMP;
			upper_compare_value_ff <= `TPC_RST_CMP;
		end else if (wr_acc) begin
			if (wr_low_cmp) begin
				low_phase_compare_ff <= i_pwdata[7:0];
			end
			if (wr_high_cmp) begin
				high_phase_compare_ff <= i_pwdata[7:0];
			end
			if (wr_upper_cmp) begin
				upper_compare_value_ff <= i_pwdata[7:0];
			end
		end
	end

	// control registers, each bit individually writable through the byte
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			timer_b_control_ff <= `TPC_RST_CTL;
			timer_a_control_ff <= `TPC_RST_CTL;
		end else if (wr_acc) begin
			if (wr_b_ctl) begin
				timer_b_control_ff <= i_pwdata[7:0];
			end
			if (wr_a_ctl) begin
				timer_a_control_ff <= i_pwdata[7:0];
			end
		end
	end

	// lower count register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			lower_count_reg_ff <= 8'h00;
		end else if (b_start) begin
			lower_count_reg_ff <= 8'h00;
		end else begin
			lower_count_reg_ff <= nxt_lower;
		end
	end

	// upper count register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			upper_count_reg_ff <= 8'h00;
		end else if (a_start || (b_start && mode == TPC16_MODE_CASCADE)) begin
			upper_count_reg_ff <= 8'h00;
		end else begin
			upper_count_reg_ff <= nxt_upper;
		end
	end

	// compare phase alternation
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			phase_ff <= TPC16_PH_HIGH;
		end else if (b_start) begin
			phase_ff <= TPC16_PH_HIGH;
		end else if (pwm_match) begin
			phase_ff <= (phase_ff == TPC16_PH_HIGH) ? TPC16_PH_LOW
				: TPC16_PH_HIGH;
		end
	end

	// output toggle flop
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wave_toggle_ff <= 1'b0;
		end else if (b_start) begin
			wave_toggle_ff <= 1'b0;
		end else if (pwm_match || casc_match) begin
			wave_toggle_ff <= !wave_toggle_ff;
		end
	end

	// interrupt request flag; a set beats a simultaneous clear
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			timer_b_irq_flag_ff <= 1'b0;
		end else if (irq_set) begin
			timer_b_irq_flag_ff <= 1'b1;
		end else if (b_start || irq_clr_sw) begin
			timer_b_irq_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			irq_pulse_ff <= 1'b0;
		end else begin
			irq_pulse_ff <= irq_set;
		end
	end

	// read data captured in the setup cycle, answered with no wait state
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup_rd) begin
			pslverr_ff <= !addr_hit;
			case (i_paddr)
				`TPC_OFS_B_MODE:    prdata_ff <= {24'h0, timer_b_mode_ctl_ff};
				`TPC_OFS_LOW_CMP:   prdata_ff <= {24'h0, low_phase_compare_ff};
				`TPC_OFS_HIGH_CMP:  prdata_ff <= {24'h0, high_phase_compare_ff};
				`TPC_OFS_LOWER_CNT: prdata_ff <= {24'h0, lower_count_reg_ff};
				`TPC_OFS_B_CTL:     prdata_ff <= {24'h0, timer_b_control_ff};
				`TPC_OFS_STATUS:    prdata_ff <= {31'h0, timer_b_irq_flag_ff};
				`TPC_OFS_A_MODE:    prdata_ff <= {24'h0, timer_a_mode_ctl_ff};
				`TPC_OFS_UPPER_CMP: prdata_ff <= {24'h0, upper_compare_value_ff};
				`TPC_OFS_UPPER_CNT: prdata_ff <= {24'h0, upper_count_reg_ff};
				`TPC_OFS_A_CTL:     prdata_ff <= {24'h0, timer_a_control_ff};
				default:            prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// pins held low unless enabled
	assign o_wave_out_pin  = timer_b_control_ff[`TPC_OUT_EN_BIT] && wave_toggle_ff;
	assign o_upper_out_pin = timer_a_control_ff[`TPC_OUT_EN_BIT] && wave_toggle_ff &&
		mode == TPC16_MODE_CASCADE;
	assign o_timer_b_irq_flag      = timer_b_irq_flag_ff;
	assign o_timer_b_irq_set_pulse = irq_pulse_ff;
endmodule : tpc16_top

// file: test/tpc16_top_assertions.sv
// port-level assertions of the cascaded pwm timer
`timescale 1ns/1ps
`include "tpc16_cfg.svh"
module tpc16_top_assertions (
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_wave_out_pin,
	input wire logic        o_upper_out_pin,
	input wire logic        o_timer_b_irq_flag,
	input wire logic        o_timer_b_irq_set_pulse
);
	logic mapped;
	logic acc;
	logic acc_wr;
	assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr >= `TPC_OFS_B_MODE)
		&& (i_paddr <= `TPC_OFS_A_CTL);
	assign acc = i_psel && i_penable;
	assign acc_wr = acc && i_pwrite && i_pstrb[0];
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	AST_PREADY_HIGH: assert property (acc |-> o_pready)
		else $error("access phase without ready");
	AST_ERR_ONLY_ACCESS: assert property (o_pslverr |-> acc)
		else $error("error flag outside access phase");
	AST_ERR_DECODE: assert property (acc |-> (o_pslverr == !mapped))
		else $error("error flag disagrees with address decode");
	AST_RDATA_UPPER: assert property (acc |-> (o_prdata[31:8] == 24'h0))
		else $error("upper read data bits not zero");
	AST_PULSE_AFTER_FLAG: assert property ($rose(o_timer_b_irq_flag) |-> o_timer_b_irq_set_pulse)
		else $error("no set pulse after flag rose");
	AST_PULSE_SINGLE: assert property (o_timer_b_irq_set_pulse |=> !o_timer_b_irq_set_pulse)
		else $error("set pulse longer than one cycle");
	AST_PULSE_NEEDS_FLAG: assert property (o_timer_b_irq_set_pulse |-> o_timer_b_irq_flag)
		else $error("set pulse without flag");
	AST_START_CLEARS: assert property (acc_wr && i_paddr == `TPC_OFS_B_MODE && i_pwdata[3]
		|-> ##2 (!o_timer_b_irq_flag && !o_wave_out_pin))
		else $error("start did not clear flag and output");
	AST_FLAG_CLEAR: assert property (acc_wr && i_paddr == `TPC_OFS_STATUS && i_pwdata[0]
		|=> (!o_timer_b_irq_flag || o_timer_b_irq_set_pulse))
		else $error("flag not cleared by write of one");
	AST_OE_LOW: assert property (acc_wr && i_paddr == `TPC_OFS_B_CTL && !i_pwdata[0]
		|=> !o_wave_out_pin [*2])
		else $error("output pin high with enable cleared");

	cover property (o_timer_b_irq_set_pulse);
	cover property (o_pslverr);
	cover property ($rose(o_upper_out_pin));
endmodule : tpc16_top_assertions

bind tpc16_top tpc16_top_assertions i_tpc16_top_assertions (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_wave_out_pin(o_wave_out_pin), .o_upper_out_pin(o_upper_out_pin),
	.o_timer_b_irq_flag(o_timer_b_irq_flag),
	.o_timer_b_irq_set_pulse(o_timer_b_irq_set_pulse)
);

// file: test/tb_tpc16_top.sv
// self-checking bench of the cascaded pwm timer
`timescale 1ns/1ps
`include "tpc16_cfg.svh"
module tb_tpc16_top;
	logic        i_sys_clk;
	logic        i_rst;
	logic        i_psel;
	logic        i_penable;
	logic        i_pwrite;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata;
	logic [3:0]  i_pstrb;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        o_wave_out_pin;
	logic        o_upper_out_pin;
	logic        o_timer_b_irq_flag;
	logic        o_timer_b_irq_set_pulse;
	int          err_total;
	int          total_checks;
	logic [31:0] rd;
	logic [31:0] keep;
	logic        err_seen;
	logic        up0;
	int          n;
	int          hi;
	int          lo;
	int          divs [8] = '{0, 0, 2, 1, 1024, 256, 64, 16};

	tpc16_top i_tpc16_top (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_wave_out_pin(o_wave_out_pin), .o_upper_out_pin(o_upper_out_pin),
		.o_timer_b_irq_flag(o_timer_b_irq_flag),
		.o_timer_b_irq_set_pulse(o_timer_b_irq_set_pulse)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task automatic timeout;
		err_total++;
		$display("unexpected at %0t: wait ran out", $time);
		end_of_test();
	endtask : timeout

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// one apb transfer; answer taken at the edge that sees pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge i_sys_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_sys_clk);
		i_penable <= 1'b1;
		rdy = 1'b0;
		for (int k = 0; k < 50 && rdy !== 1'b1; k++) begin
			@(posedge i_sys_clk);
			rd = o_prdata;
			err_seen = o_pslverr;
			rdy = o_pready;
		end
		if (rdy !== 1'b1)
			timeout();
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp, "read");
	endtask : rdchk

	task automatic wait_pin(input logic lvl, output int c);
		for (c = 1; c < 20000; c++) begin
			@(negedge i_sys_clk);
			if (o_wave_out_pin === lvl)
				return;
		end
		timeout();
	endtask : wait_pin

	task automatic wait_pulse(output int c);
		for (c = 1; c < 20000; c++) begin
			@(negedge i_sys_clk);
			if (o_timer_b_irq_set_pulse === 1'b1)
				return;
		end
		timeout();
	endtask : wait_pulse

	// pulses and output-high cycles over a window
	task automatic watch(input int cyc, output int p, output int h);
		p = 0;
		h = 0;
		repeat (cyc) begin
			@(negedge i_sys_clk);
			p += (o_timer_b_irq_set_pulse === 1'b1);
			h += (o_wave_out_pin === 1'b1);
		end
	endtask : watch

	initial begin
		i_rst = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h0;
		i_pwdata = 32'h0;
		i_pstrb = 4'hf;
		err_total = 0;
		total_checks = 0;
		repeat (3) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		for (n = 0; n < 10; n++)
			rdchk(`TPC_OFS_B_MODE + 12'(4 * n), 32'h0);
		apb(1'b0, 12'hfb8, 32'h0);
		check({31'h0, err_seen}, 32'h1, "unmapped error");
		i_pstrb <= 4'h0;
		wr(`TPC_OFS_B_CTL, 8'h01);
		i_pstrb <= 4'hf;
		rdchk(`TPC_OFS_B_CTL, 32'h0);
		$display("test registers done");

		wr(`TPC_OFS_HIGH_CMP, 8'h01);
		wr(`TPC_OFS_LOW_CMP, 8'h02);
		wr(`TPC_OFS_B_CTL, 8'h01);
		wr(`TPC_OFS_B_MODE, 8'h3d);
		rdchk(`TPC_OFS_B_MODE, 32'h35);
		wait_pin(1'b1, n);
		wait_pin(1'b0, hi);
		wait_pin(1'b1, lo);
		check(hi, 3, "low phase length");
		check(lo, 2, "high phase length");
		watch(50, n, hi);
		check(n, 10, "pulses per window");
		wr(`TPC_OFS_B_MODE, 8'h31);
		apb(1'b0, `TPC_OFS_LOWER_CNT, 32'h0);
		keep = rd;
		repeat (10) @(posedge i_sys_clk);
		rdchk(`TPC_OFS_LOWER_CNT, keep);
		rdchk(`TPC_OFS_STATUS, 32'h1);
		wr(`TPC_OFS_STATUS, 8'h01);
		rdchk(`TPC_OFS_STATUS, 32'h0);
		wr(`TPC_OFS_B_MODE, 8'h3d);
		watch(20, n, hi);
		wr(`TPC_OFS_B_MODE, 8'h39);
		rdchk(`TPC_OFS_STATUS, 32'h0);
		rdchk(`TPC_OFS_LOWER_CNT, 32'h0);
		wr(`TPC_OFS_B_MODE, 8'h3d);
		wr(`TPC_OFS_B_CTL, 8'h00);
		watch(30, n, hi);
		check(hi, 0, "pin high while disabled");
		$display("test pwm done");

		wr(`TPC_OFS_HIGH_CMP, 8'h01);
		wr(`TPC_OFS_LOW_CMP, 8'h01);
		wr(`TPC_OFS_B_CTL, 8'h01);
		for (int c = 2; c < 8; c++) begin
			wr(`TPC_OFS_B_MODE, {1'b0, 3'(c), 4'hd});
			// let the start cycle clear the toggle flop first
			@(posedge i_sys_clk);
			wait_pin(1'b1, n);
			wait_pin(1'b0, hi);
			wait_pin(1'b1, lo);
			check(hi + lo, 4 * divs[c], "period");
		end
		wr(`TPC_OFS_B_MODE, 8'h0d);
		// a match on the write edge still pulses once
		@(posedge i_sys_clk);
		watch(100, n, hi);
		check(n, 0, "pulses on prohibited code");
		$display("test clock select done");

		wr(`TPC_OFS_B_MODE, 8'h00);
		wr(`TPC_OFS_UPPER_CMP, 8'h01);
		wr(`TPC_OFS_LOW_CMP, 8'h02);
		wr(`TPC_OFS_A_CTL, 8'h01);
		wr(`TPC_OFS_B_CTL, 8'h00);
		wr(`TPC_OFS_A_MODE, 8'h22);
		wr(`TPC_OFS_B_MODE, 8'h3e);
		wait_pulse(n);
		up0 = o_upper_out_pin;
		wait_pulse(n);
		check(n, 259, "cascade interval");
		check({31'h0, o_upper_out_pin}, {31'h0, ~up0}, "upper pin toggle");
		check({31'h0, o_wave_out_pin}, 32'h0, "wave pin disabled");
		$display("test cascade done");
		end_of_test();
	end
endmodule : tb_tpc16_top
